// ===== core/aalme_exec.sv
// Functional notes
// - operands from register-space sram, from the flags register at FLAGS_ADDR, or the immediate source byte
// - result written back to dest register, dropped when dest is FLAGS_ADDR
// - test_mask ands, flags like and, no write
// - compare_sub subtracts, flags like sub, no write
// - register row 0x40, immediate row 0x50
// - sign and zero from 8-bit result
// - carry only for arithmetic operations
// - carry high means borrow on subtracts
// - wait states add pad cycles after exec, not sram read cycles
// - at most six cycles without wait states
`timescale 1ns/1ns
module aalme_exec (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire aalme_pkg::aalme_req_t req,
  input wire aalme_pkg::aalme_host_t host,
  output logic [aalme_pkg::DATA_W-1:0] host_rdata,
  output logic host_rvalid,
  output logic busy,
  output logic done,
  output logic bad_opcode,
  output logic [aalme_pkg::DATA_W-1:0] cpu_condition_flags,
  output logic irq_enable
);
  import aalme_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    aalme_state_t st;
    logic [CNT_W-1:0] cnt;
    aalme_req_t req;
    logic [DATA_W-1:0] dst;
    logic [DATA_W-1:0] flags;
    logic busy;
    logic done;
    logic bad;
    logic rd_pend;
    logic rd_flags;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } aalme_regs_t;

  aalme_regs_t s_ff;
  aalme_regs_t nxt_s;

  logic mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;

  logic [7:0] base_op;
  logic is_imm;
  logic is_alu;
  logic [DATA_W-1:0] op_s;
  logic [DATA_W-1:0] res;
  logic [DATA_W:0] sum9;
  logic [DATA_W:0] diff9;
  logic cin;
  logic upd_c;
  logic wr_res;
  logic [CNT_W-1:0] total;

  // ---------------------------------------------------------------
  // register-space sram
  // ---------------------------------------------------------------
  aalme_regmem u_mem (
    .clk(clk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_ff(mem_rdata)
  );

  // decode of the incoming request and its length
  always_comb begin
    is_imm = (req.opcode[7:4] == ROW_IMM);
    base_op = is_imm ? 8'(req.opcode - IMM_OFFSET) : req.opcode;
    is_alu = ((req.opcode[7:4] == ROW_REG) &&
              (req.opcode <= OP_DECREMENT)) ||
             (is_imm && (base_op <= OP_ADC));
    if (is_imm) begin
      total = 8'(CYC_IMM + WS_IMM * 8'(req.ws));
    end else if (base_op == OP_INC || base_op == OP_DECREMENT) begin
      total = 8'(CYC_INCDEC + WS_INCDEC * 8'(req.ws));
    end else if (is_alu) begin
      total = 8'(CYC_REG + WS_REG * 8'(req.ws));
    end else begin
      total = 8'(CYC_MISC + WS_MISC * 8'(req.ws));
    end
  end

  // alu on the latched instruction
  always_comb begin
    if (s_ff.req.opcode[7:4] == ROW_IMM) begin
      op_s = s_ff.req.src;
    end else if (s_ff.req.src == FLAGS_ADDR) begin
      op_s = s_ff.flags;
    end else begin
      op_s = mem_rdata;
    end
    cin = s_ff.flags[FLG_C];
    sum9 = 9'({1'b0, s_ff.dst}) + 9'({1'b0, op_s});
    diff9 = 9'({1'b0, s_ff.dst}) - 9'({1'b0, op_s});
    res = s_ff.dst;
    upd_c = 1'b1;
    wr_res = 1'b1;
    case (s_ff.req.opcode[7:4] == ROW_IMM ?
          8'(s_ff.req.opcode - IMM_OFFSET) : s_ff.req.opcode)
      OP_AND: begin
        res = s_ff.dst & op_s;
        upd_c = 1'b0;
      end
      OP_TEST_MASK: begin
        res = s_ff.dst & op_s;
        upd_c = 1'b0;
        wr_res = 1'b0;
      end
      OP_OR: begin
        res = s_ff.dst | op_s;
        upd_c = 1'b0;
      end
      OP_XOR: begin
        res = s_ff.dst ^ op_s;
        upd_c = 1'b0;
      end
      OP_SUB: res = diff9[DATA_W-1:0];
      OP_COMPARE_SUB: begin
        res = diff9[DATA_W-1:0];
        wr_res = 1'b0;
      end
      OP_SUB_BORROW: begin
        diff9 = diff9 - 9'({8'h00, cin});
        res = diff9[DATA_W-1:0];
      end
      OP_ADD: res = sum9[DATA_W-1:0];
      OP_ADC: begin
        sum9 = sum9 + 9'({8'h00, cin});
        res = sum9[DATA_W-1:0];
      end
      OP_INC: begin
        sum9 = 9'({1'b0, s_ff.dst}) + 9'h001;
        res = sum9[DATA_W-1:0];
      end
      OP_DECREMENT: begin
        diff9 = 9'({1'b0, s_ff.dst}) - 9'h001;
        res = diff9[DATA_W-1:0];
      end
      default: begin
        upd_c = 1'b0;
        wr_res = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer, flags and host port
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    nxt_s.rvalid = 1'b0;
    nxt_s.rd_pend = 1'b0;
    mem_we = 1'b0;
    mem_addr = host.addr;
    mem_wdata = host.wdata;
    // host read data, two cycles after the request
    if (s_ff.rd_pend) begin
      nxt_s.rdata = s_ff.rd_flags ? s_ff.flags : mem_rdata;
      nxt_s.rvalid = 1'b1;
    end
    case (s_ff.st)
      ST_IDLE: begin
        if (start) begin
          nxt_s.req = req;
          nxt_s.busy = 1'b1;
          nxt_s.cnt = 8'(total - CNT_LAST);
          nxt_s.bad = !is_alu && (req.opcode > OP_IRQ_ON);
          nxt_s.st = is_alu ? ST_RD_DST : ST_PAD;
          case (req.opcode)
            OP_CARRY_CLEAR: nxt_s.flags[FLG_C] = 1'b0;
            OP_CARRY_SET: nxt_s.flags[FLG_C] = 1'b1;
            OP_CARRY_INVERT: nxt_s.flags[FLG_C] = !s_ff.flags[FLG_C];
            OP_IRQ_OFF: nxt_s.flags[FLG_IE] = 1'b0;
            OP_IRQ_ON: nxt_s.flags[FLG_IE] = 1'b1;
            default: nxt_s.flags = s_ff.flags;
          endcase
        end else if (host.wr) begin
          if (host.addr == FLAGS_ADDR) begin
            nxt_s.flags = host.wdata & FLAGS_MASK;
          end else begin
            mem_we = 1'b1;
          end
        end else if (host.rd) begin
          nxt_s.rd_pend = 1'b1;
          nxt_s.rd_flags = (host.addr == FLAGS_ADDR);
        end
      end
      ST_RD_DST: begin
        mem_addr = s_ff.req.dest;
        nxt_s.st = ST_RD_SRC;
      end
      ST_RD_SRC: begin
        nxt_s.dst = (s_ff.req.dest == FLAGS_ADDR) ?
                    s_ff.flags : mem_rdata;
        mem_addr = s_ff.req.src;
        nxt_s.st = ST_EXEC;
      end
      ST_EXEC: begin
        mem_addr = s_ff.req.dest;
        mem_wdata = res;
        mem_we = wr_res && (s_ff.req.dest != FLAGS_ADDR);
        nxt_s.flags[FLG_S] = res[DATA_W-1];
        nxt_s.flags[FLG_Z] = (res == '0);
        if (upd_c) begin
          nxt_s.flags[FLG_C] = sum9[DATA_W] | diff9[DATA_W];
          if (s_ff.req.opcode[3:0] >= OP_SUB[3:0] &&
              s_ff.req.opcode[3:0] <= OP_SUB_BORROW[3:0] ||
              s_ff.req.opcode == OP_DECREMENT) begin
            nxt_s.flags[FLG_C] = diff9[DATA_W];
          end else begin
            nxt_s.flags[FLG_C] = sum9[DATA_W];
          end
        end
        nxt_s.st = ST_PAD;
      end
      default: nxt_s.st = ST_PAD;
    endcase
    // cycle count, padded by wait states
    if (s_ff.busy) begin
      if (s_ff.cnt == CNT_LAST) begin
        nxt_s.st = ST_IDLE;
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
      end else begin
        nxt_s.cnt = 8'(s_ff.cnt - CNT_LAST);
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_ff <= '0;
      s_ff.st <= ST_IDLE;
      s_ff.flags <= FLAGS_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from state
  assign host_rdata = s_ff.rdata;
  assign host_rvalid = s_ff.rvalid;
  assign busy = s_ff.busy;
  assign done = s_ff.done;
  assign bad_opcode = s_ff.bad;
  assign cpu_condition_flags = s_ff.flags;
  assign irq_enable = s_ff.flags[FLG_IE];

endmodule // aalme_exec

// ===== core/aalme_pkg.sv
package aalme_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned WS_W = 4;
  localparam int unsigned CNT_W = 8;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_IDLE = 8'h00;
  localparam logic [7:0] OP_CARRY_CLEAR = 8'h01;
  localparam logic [7:0] OP_CARRY_SET = 8'h02;
  localparam logic [7:0] OP_CARRY_INVERT = 8'h03;
  localparam logic [7:0] OP_IRQ_OFF = 8'h04;
  localparam logic [7:0] OP_IRQ_ON = 8'h05;
  localparam logic [7:0] OP_AND = 8'h40;
  localparam logic [7:0] OP_TEST_MASK = 8'h41;
  localparam logic [7:0] OP_OR = 8'h42;
  localparam logic [7:0] OP_XOR = 8'h43;
  localparam logic [7:0] OP_SUB = 8'h44;
  localparam logic [7:0] OP_COMPARE_SUB = 8'h45;
  localparam logic [7:0] OP_SUB_BORROW = 8'h46;
  localparam logic [7:0] OP_ADD = 8'h47;
  localparam logic [7:0] OP_ADC = 8'h48;
  localparam logic [7:0] OP_INC = 8'h49;
  localparam logic [7:0] OP_DECREMENT = 8'h4A;
  localparam logic [7:0] IMM_OFFSET = 8'h10;
  localparam logic [3:0] ROW_REG = 4'h4;
  localparam logic [3:0] ROW_IMM = 4'h5;
  localparam logic [3:0] ROW_MISC = 4'h0;

  // ---------------------------------------------------------------
  // condition flags register
  // ---------------------------------------------------------------
  localparam logic [7:0] FLAGS_ADDR = 8'hFF;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] FLAGS_MASK = 8'h0F;
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_S = 2;
  localparam int unsigned FLG_IE = 3;

  // ---------------------------------------------------------------
  // cycle counts: base and extra per wait state
  // ---------------------------------------------------------------
  localparam logic [7:0] CYC_MISC = 8'h02;
  localparam logic [7:0] WS_MISC = 8'h01;
  localparam logic [7:0] CYC_REG = 8'h06;
  localparam logic [7:0] WS_REG = 8'h03;
  localparam logic [7:0] CYC_IMM = 8'h05;
  localparam logic [7:0] WS_IMM = 8'h03;
  localparam logic [7:0] CYC_INCDEC = 8'h05;
  localparam logic [7:0] WS_INCDEC = 8'h02;
  localparam logic [7:0] CNT_LAST = 8'h01;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_DST = 3'b001,
    ST_RD_SRC = 3'b010,
    ST_EXEC = 3'b011,
    ST_PAD = 3'b100
  } aalme_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] dest;
    logic [7:0] src;
    logic [WS_W-1:0] ws;
  } aalme_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } aalme_host_t;

endpackage

// ===== core/aalme_regmem.sv
`timescale 1ns/1ns
module aalme_regmem (
  input wire logic clk,
  input wire logic we,
  input wire logic [aalme_pkg::ADDR_W-1:0] addr,
  input wire logic [aalme_pkg::DATA_W-1:0] wdata,
  output logic [aalme_pkg::DATA_W-1:0] rdata_ff
);
  import aalme_pkg::*;

  logic [DATA_W-1:0] mem_ff [0:(1<<ADDR_W)-1];

  // register-space sram, registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem_ff[addr] <= wdata;
    end
    rdata_ff <= mem_ff[addr];
  end

endmodule // aalme_regmem

// ===== dv/aalme_exec_properties.sv
`timescale 1ns/1ns
module aalme_exec_properties
  import aalme_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire aalme_pkg::aalme_req_t req,
  input wire aalme_pkg::aalme_host_t host,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic busy,
  input wire logic done,
  input wire logic bad_opcode,
  input wire logic [7:0] cpu_condition_flags,
  input wire logic irq_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // --------------------------------------------------
  // accepted instruction, and the zero wait state case
  // --------------------------------------------------
  logic tk;
  logic go;
  logic [7:0] op;
  assign tk = start && !busy;
  assign go = tk && req.ws == 4'h0;
  assign op = req.opcode;
  a_misc_len: assert property (go && op <= 8'h05 |=> !done ##1 done)
    else $error("misc op length wrong");
  a_reg_len: assert property (go && op inside {[8'h40:8'h48]}
    |=> !done [*5] ##1 done) else $error("reg form length wrong");
  a_imm_len: assert property (go && op inside {[8'h50:8'h58]}
    |=> !done [*4] ##1 done) else $error("imm form length wrong");
  a_step_len: assert property (go && op inside {8'h49, 8'h4A}
    |=> !done [*4] ##1 done) else $error("inc/dec length wrong");
  a_logic_carry: assert property (tk && op[7:5] == 3'b010
    && op[3:0] <= 4'h3 |-> ##5
    cpu_condition_flags[0] == $past(cpu_condition_flags[0], 5))
    else $error("logic op changed carry");
  a_carry_fixed: assert property (tk && op inside {8'h01, 8'h02}
    |=> cpu_condition_flags[0] == $past(req.opcode[1]))
    else $error("carry set/clear wrong");
  a_carry_invert: assert property (tk && op == 8'h03
    |=> cpu_condition_flags[0] != $past(cpu_condition_flags[0]))
    else $error("carry not inverted");
  a_irq_ops: assert property (tk && op inside {8'h04, 8'h05}
    |=> irq_enable == $past(req.opcode[0])) else $error("irq op wrong");
  a_irq_mirror: assert property (irq_enable == cpu_condition_flags[3])
    else $error("irq enable differs from flags");
  a_bad_flag: assert property (tk && op == 8'h30 |=> bad_opcode)
    else $error("unknown opcode not flagged");
  a_busy_read: assert property (busy && host.rd |-> ##2 !host_rvalid)
    else $error("read accepted while busy");
endmodule // aalme_exec_properties

bind aalme_exec aalme_exec_properties u_props (.clk(clk), .srst(srst),
  .start(start), .req(req), .host(host), .host_rdata(host_rdata),
  .host_rvalid(host_rvalid), .busy(busy), .done(done),
  .bad_opcode(bad_opcode), .cpu_condition_flags(cpu_condition_flags),
  .irq_enable(irq_enable));

// ===== dv/aalme_testbench.sv
`timescale 1ns/1ns
module testbench;
  import aalme_pkg::*;
  logic clk, srst, start, host_rvalid, busy, done, bad_opcode, irq_enable;
  aalme_req_t req;
  aalme_host_t host;
  logic [7:0] host_rdata, flags, rd_v;
  int n_fail, n_tests, len;
  // alu table: opcode, dest, source, result, flags
  logic [7:0] t_op [19] = '{8'h47, 8'h48, 8'h44, 8'h40, 8'h46, 8'h45,
    8'h51, 8'h42, 8'h53, 8'h49, 8'h4A, 8'h55, 8'h57, 8'h56,
    8'h43, 8'h54, 8'h58, 8'h50, 8'h52};
  logic [7:0] t_d [19] = '{8'h80, 8'h01, 8'h10, 8'h0F, 8'h05, 8'h05,
    8'hF0, 8'h81, 8'hAA, 8'hFF, 8'h00, 8'h05, 8'h7F, 8'h10,
    8'h3C, 8'h01, 8'hFE, 8'hC3, 8'h00};
  logic [7:0] t_s [19] = '{8'h80, 8'h01, 8'h20, 8'hF0, 8'h03, 8'h05,
    8'h80, 8'h02, 8'hAA, 8'h00, 8'h00, 8'h06, 8'h01, 8'h0F,
    8'h0F, 8'h02, 8'h01, 8'h81, 8'h00};
  logic [7:0] t_r [19] = '{8'h00, 8'h03, 8'hF0, 8'h00, 8'h01, 8'h05,
    8'hF0, 8'h83, 8'h00, 8'h00, 8'hFF, 8'h05, 8'h80, 8'h01,
    8'h33, 8'hFF, 8'h00, 8'h81, 8'h00};
  logic [7:0] t_f [19] = '{8'h03, 8'h00, 8'h05, 8'h03, 8'h00, 8'h02,
    8'h04, 8'h04, 8'h02, 8'h03, 8'h05, 8'h05, 8'h04, 8'h00,
    8'h00, 8'h05, 8'h03, 8'h05, 8'h03};
  // misc table: opcode, flags after
  logic [7:0] m_op [8] = '{8'h02, 8'h03, 8'h03, 8'h01, 8'h05, 8'h04,
    8'h30, 8'h00};
  logic [7:0] m_f [8] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h08, 8'h00,
    8'h00, 8'h00};

  aalme_exec dut (.clk(clk), .srst(srst), .start(start), .req(req),
    .host(host), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .busy(busy), .done(done), .bad_opcode(bad_opcode),
    .cpu_condition_flags(flags), .irq_enable(irq_enable));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic hwr(input logic [7:0] a, input logic [7:0] d);
    host = '{1'b0, 1'b1, a, d};
    step();
    host = '0;
    // idle cycle so a following request never reassigns host at once
    step();
  endtask
  // read with bounded wait for the valid pulse
  task automatic hrd(input logic [7:0] a);
    int n;
    host = '{1'b1, 1'b0, a, 8'h00};
    step();
    host = '0;
    n = 0;
    while (host_rvalid !== 1'b1 && n < 5) begin
      step();
      n++;
    end
    if (host_rvalid !== 1'b1) begin
      n_fail++;
      print_verdict();
    end else begin
      rd_v = host_rdata;
    end
  endtask
  // one instruction, len counts cycles up to done
  task automatic run(input logic [7:0] op, d, s, input int ws);
    req = '{op, d, s, 4'(ws)};
    start = 1'b1;
    step();
    start = 1'b0;
    len = 1;
    while (done !== 1'b1 && len < 40) begin
      step();
      len++;
    end
    if (done !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask
  function automatic logic [7:0] exp_len(input logic [7:0] op, input int ws);
    if (op inside {8'h49, 8'h4A}) return 8'(5 + 2 * ws);
    if (op[7:4] == 4'h4) return 8'(6 + 3 * ws);
    if (op[7:4] == 4'h5) return 8'(5 + 3 * ws);
    return 8'(2 + ws);
  endfunction

  task automatic t_misc();
    for (int i = 0; i < 8; i++) begin
      run(m_op[i], 8'h00, 8'h00, i % 3);
      chk(8'(len), exp_len(m_op[i], i % 3));
      chk(flags, m_f[i]);
      chk({7'h00, bad_opcode}, {7'h00, m_op[i] == 8'h30});
      chk({7'h00, irq_enable}, {7'h00, m_f[i][3]});
    end
  endtask
  task automatic t_alu();
    for (int i = 0; i < 19; i++) begin
      hwr(8'h10, t_d[i]);
      hwr(8'h11, t_s[i]);
      run(t_op[i], 8'h10, t_op[i][4] ? t_s[i] : 8'h11, i % 3);
      chk(8'(len), exp_len(t_op[i], i % 3));
      chk(flags, t_f[i]);
      hrd(8'h10);
      chk(rd_v, t_r[i]);
    end
  endtask
  // host write and second start while busy are both dropped
  task automatic t_refuse();
    hwr(8'h10, 8'h01);
    hwr(8'h11, 8'h02);
    req = '{OP_ADD, 8'h10, 8'h11, 4'h3};
    start = 1'b1;
    step();
    start = 1'b0;
    hwr(8'h10, 8'h55);
    // read while busy: no valid pulse may follow
    host = '{1'b1, 1'b0, 8'h10, 8'h00};
    step();
    host = '0;
    chk({7'h00, busy}, 8'h01);
    step();
    chk({7'h00, host_rvalid}, 8'h00);
    run(OP_CARRY_SET, 8'h00, 8'h00, 0);
    hrd(8'h10);
    chk(rd_v, 8'h03);
    chk(flags, 8'h00);
    hwr(FLAGS_ADDR, 8'hF4);
    chk(flags, 8'h04);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial begin
    srst = 1'b1;
    start = 1'b0;
    req = '0;
    host = '0;
    n_fail = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    chk(flags, FLAGS_RESET);
    t_misc();
    t_alu();
    t_refuse();
    print_verdict();
  end
endmodule // testbench
